// ==== hdl/fmcr_pkg.sv ====
/*
 * Shared constants of the frame mirror and CPU redirect block: register
 * offsets, field positions, reset values, command codes and FSM states.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package fmcr_pkg;

	// ==========================================================
	// bus
	localparam int          AXI_AW        = 8;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ==========================================================
	// register offsets
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_MIR_DEST  = 8'h04;
	localparam logic [7:0]  OFF_EGR_MASK  = 8'h08;
	localparam logic [7:0]  OFF_ING_EN    = 8'h0C;
	localparam logic [7:0]  OFF_SLOW_EN   = 8'h10;
	localparam logic [7:0]  OFF_V4_EN     = 8'h14;
	localparam logic [7:0]  OFF_V6_EN     = 8'h18;
	localparam logic [7:0]  OFF_CPUQ      = 8'h1C;
	localparam logic [7:0]  OFF_VLAN      = 8'h20;
	localparam logic [7:0]  OFF_MAC_IDX   = 8'h24;
	localparam logic [7:0]  OFF_MAC_LO    = 8'h28;
	localparam logic [7:0]  OFF_MAC_HI    = 8'h2C;
	localparam logic [7:0]  OFF_MAC_CMD   = 8'h30;
	localparam logic [7:0]  OFF_MIR_CNT   = 8'h34;

	// ==========================================================
	// fields
	localparam int          CTL_MIR_CPU   = 0;
	localparam int          CTL_LRN_MIR   = 1;
	localparam int          Q_W           = 3;
	localparam int          QM_LSB        = 0;
	localparam int          QI_LSB        = 4;
	localparam int          QL_LSB        = 8;
	localparam int          QS_LSB        = 12;
	localparam int          VLAN_FLAG_BIT = 16;
	localparam int          VID_W         = 12;
	localparam int          VLAN_DEPTH    = 4096;
	localparam int          MAC_ENTRY_W   = 61;
	localparam int          HI_VALID_BIT  = 31;
	localparam int          HI_VID_LSB    = 16;
	localparam logic [47:0] SLOW_PROTO_MAC = 48'h0180C2000002;
	localparam logic [31:0] RST_ZERO      = 32'h00000000;

	// ==========================================================
	// MAC table commands and states
	typedef enum logic [1:0] {
		CMD_IDLE    = 2'b00,
		CMD_READ    = 2'b01,
		CMD_WRITE   = 2'b10,
		CMD_GETNEXT = 2'b11
	} fmcr_cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_CHECK = 2'b10
	} fmcr_state_t;

endpackage

// ==== hdl/fmcr_ram.sv ====
/*
 * Simple dual-port memory: one write port, one read port whose data
 * come out of a register one clock after the address.
 * Assumes a single clock; the array itself is not reset.
 */
`timescale 1ns/10ps
module fmcr_ram #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_we,
	input  wire logic [AW-1:0]    i_waddr,
	input  wire logic [WIDTH-1:0] i_wdata,
	input  wire logic [AW-1:0]    i_raddr,
	output logic      [WIDTH-1:0] o_rdata
);

	if (WIDTH < 1 || DEPTH < 2 || AW < $clog2(DEPTH)) begin : g_chk
		$error("fmcr_ram needs WIDTH >= 1, DEPTH >= 2, AW wide enough");
	end

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge i_ref_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end

endmodule

// ==== hdl/fmcr_top.sv ====
/*
 * Frame mirror and CPU redirect decision with its AXI4-Lite registers
 * and indirect / direct MAC table access.
 * Assumes frame descriptors arrive one per cycle, synchronous to
 * i_ref_clk, and that the egress side takes every decision.
 */
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
// How it works
// RULE_01 - per-port enable sends slow-protocol multicast DMAC frames to the CPU
// RULE_02 - ingress-mirror ports copy every received frame to the mirror mask
// RULE_03 - frames forwarded to egress-mirror ports are copied to mirror mask
// RULE_04 - frames on VLANs with mirror flag set are copied to mirror mask
// RULE_05 - with CPU mirroring on, CPU-bound frames are copied to mirror mask
// RULE_06 - mirror destination is a port mask that may include the CPU
// RULE_07 - mirrored copies to the CPU use the mirror CPU queue
// RULE_08 - with learn mirroring on, learn frames are copied to mirror mask
// RULE_09 - a classifier action can request a mirror copy
// RULE_10 - all mirror conditions may be active together on one mask
// RULE_11 - a probe mirrored both ways yields both copies on the mirror port; the code sends one copy per port (m_hit)
// RULE_12 - software gives mirror port the same egress setup as the probe
// RULE_13 - per-port enable redirects IPv4 group report frames to the CPU
// RULE_14 - per-port enable redirects IPv6 listener frames to the CPU
// RULE_15 - both redirects are independent, each with its own CPU queue
// RULE_16 - MAC table indirect access with get-next and high/low data words
// RULE_17 - MAC table direct access to an entry selected by index
// RULE_18 - one mirror copy per port; normal forwarding stays unchanged
`timescale 1ns/10ps
module fmcr_top import fmcr_pkg::*; #(
	parameter int NUM_PORTS = 8,
	parameter int MAC_DEPTH = 256,
	parameter int PW        = NUM_PORTS + 1,
	parameter int PORT_W    = $clog2(PW)
) (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_awvalid,
	output logic                   o_awready,
	input  wire logic [AXI_AW-1:0] i_awaddr,
	input  wire logic              i_wvalid,
	output logic                   o_wready,
	input  wire logic [31:0]       i_wdata,
	input  wire logic [3:0]        i_wstrb,
	output logic                   o_bvalid,
	input  wire logic              i_bready,
	output logic      [1:0]        o_bresp,
	input  wire logic              i_arvalid,
	output logic                   o_arready,
	input  wire logic [AXI_AW-1:0] i_araddr,
	output logic                   o_rvalid,
	input  wire logic              i_rready,
	output logic      [31:0]       o_rdata,
	output logic      [1:0]        o_rresp,
	input  wire logic              i_frm_valid,
	input  wire logic [PORT_W-1:0] i_frm_port,
	input  wire logic [47:0]       i_frm_dmac,
	input  wire logic              i_frm_igmp,
	input  wire logic              i_frm_mld,
	input  wire logic [VID_W-1:0]  i_frm_vid,
	input  wire logic [PW-1:0]     i_frm_fwd_mask,
	input  wire logic [Q_W-1:0]    i_frm_cpu_queue,
	input  wire logic              i_frm_learn,
	input  wire logic              i_frm_content_classifier_mirror,
	output logic                   o_dec_valid,
	output logic      [PW-1:0]     o_fwd_mask,
	output logic      [Q_W-1:0]    o_cpu_queue,
	output logic      [PW-1:0]     o_mirror_mask,
	output logic      [Q_W-1:0]    o_mirror_cpu_queue
);

	localparam int MAC_AW = $clog2(MAC_DEPTH);
	localparam int CPU    = NUM_PORTS;

	if (NUM_PORTS < 1 || NUM_PORTS > 31) begin : g_chk_ports
		$error("NUM_PORTS must be 1..31");
	end
	if (MAC_DEPTH < 2 || MAC_DEPTH > 65536 ||
	    (1 << MAC_AW) != MAC_DEPTH) begin : g_chk_depth
		$error("MAC_DEPTH must be a power of two, 2..65536");
	end

	function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
	                                           input logic [31:0] new_v,
	                                           input logic [3:0]  strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction

	// ==========================================================
	// AXI4-Lite slave handshakes
	logic        aw_rdy_q;
	logic        bvalid_q;
	logic        ar_rdy_q;
	logic        rvalid_q;
	logic [1:0]  bresp_q;
	logic [1:0]  rresp_q;
	logic [31:0] rdata_q;

	wire wr_fire = aw_rdy_q & i_awvalid & i_wvalid;
	wire rd_fire = ar_rdy_q & i_arvalid;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_rdy_q <= 1'b0;
			ar_rdy_q <= 1'b0;
		end else begin
			aw_rdy_q <= !aw_rdy_q && i_awvalid && i_wvalid && !bvalid_q;
			ar_rdy_q <= !ar_rdy_q && i_arvalid && !rvalid_q;
		end
	end

	// ==========================================================
	// register decode
	wire [7:0] wa = i_awaddr;
	wire [7:0] ra = i_araddr;
	wire w_ctrl  = wr_fire && wa == OFF_CTRL;
	wire w_dest  = wr_fire && wa == OFF_MIR_DEST;
	wire w_egr   = wr_fire && wa == OFF_EGR_MASK;
	wire w_ing   = wr_fire && wa == OFF_ING_EN;
	wire w_slow  = wr_fire && wa == OFF_SLOW_EN;
	wire w_v4    = wr_fire && wa == OFF_V4_EN;
	wire w_v6    = wr_fire && wa == OFF_V6_EN;
	wire w_cpuq  = wr_fire && wa == OFF_CPUQ;
	wire w_vlan  = wr_fire && wa == OFF_VLAN;
	wire w_idx   = wr_fire && wa == OFF_MAC_IDX;
	wire w_lo    = wr_fire && wa == OFF_MAC_LO;
	wire w_hi    = wr_fire && wa == OFF_MAC_HI;
	wire w_cmd   = wr_fire && wa == OFF_MAC_CMD;
	wire w_ok    = w_ctrl | w_dest | w_egr | w_ing | w_slow | w_v4 | w_v6 |
	               w_cpuq | w_vlan | w_idx | w_lo | w_hi | w_cmd |
	               (wa == OFF_MIR_CNT);

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= w_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (i_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// configuration registers
	logic [31:0] ctrl_q, dest_q, egr_q, ing_q, slow_q, v4_q, v6_q, cpuq_q;
	logic [31:0] vlan_q;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_q <= RST_ZERO;
			dest_q <= RST_ZERO;
			egr_q  <= RST_ZERO;
			ing_q  <= RST_ZERO;
		end else begin
			if (w_ctrl) ctrl_q <= strb_merge(ctrl_q, i_wdata, i_wstrb);
			if (w_dest) dest_q <= strb_merge(dest_q, i_wdata, i_wstrb); // [RULE_06]
			if (w_egr)  egr_q  <= strb_merge(egr_q, i_wdata, i_wstrb);
			if (w_ing)  ing_q  <= strb_merge(ing_q, i_wdata, i_wstrb);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			slow_q <= RST_ZERO;
			v4_q   <= RST_ZERO;
			v6_q   <= RST_ZERO;
			cpuq_q <= RST_ZERO;
			vlan_q <= RST_ZERO;
		end else begin
			if (w_slow) slow_q <= strb_merge(slow_q, i_wdata, i_wstrb);
			if (w_v4)   v4_q   <= strb_merge(v4_q, i_wdata, i_wstrb);
			if (w_v6)   v6_q   <= strb_merge(v6_q, i_wdata, i_wstrb);
			if (w_cpuq) cpuq_q <= strb_merge(cpuq_q, i_wdata, i_wstrb);
			if (w_vlan) vlan_q <= strb_merge(vlan_q, i_wdata, i_wstrb);
		end
	end

	wire [PW-1:0]  dest_m   = dest_q[PW-1:0];
	wire [Q_W-1:0] q_mirror = cpuq_q[QM_LSB +: Q_W];
	wire [Q_W-1:0] q_igmp   = cpuq_q[QI_LSB +: Q_W];
	wire [Q_W-1:0] q_mld    = cpuq_q[QL_LSB +: Q_W];
	wire [Q_W-1:0] q_slow   = cpuq_q[QS_LSB +: Q_W];

	// per-Flag_a flag table, written through the VLAN register
	wire vlan_rd;
	wire [31:0] vlan_wv = strb_merge(vlan_q, i_wdata, i_wstrb);

	fmcr_ram #(
		.WIDTH (1),
		.DEPTH (VLAN_DEPTH)
	) u_vlan_flag (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_we      (w_vlan),
		.i_waddr   (vlan_wv[VID_W-1:0]),
		.i_wdata   (vlan_wv[VLAN_FLAG_BIT]),
		.i_raddr   (i_frm_vid),
		.o_rdata   (vlan_rd)
	);

	// ==========================================================
	// frame stage, aligned with the flag table read
	logic              s_valid_q, s_igmp_q, s_mld_q, s_learn_q, s_content_classifier_q;
	logic [PORT_W-1:0] s_port_q;
	logic [47:0]       s_dmac_q;
	logic [PW-1:0]     s_fwd_q;
	logic [Q_W-1:0]    s_cpuq_q;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_valid_q <= 1'b0;
			s_igmp_q  <= 1'b0;
			s_mld_q   <= 1'b0;
			s_learn_q <= 1'b0;
			s_content_classifier_q  <= 1'b0;
			s_port_q  <= '0;
			s_dmac_q  <= '0;
			s_fwd_q   <= '0;
			s_cpuq_q  <= '0;
		end else begin
			s_valid_q <= i_frm_valid;
			s_igmp_q  <= i_frm_igmp;
			s_mld_q   <= i_frm_mld;
			s_learn_q <= i_frm_learn;
			s_content_classifier_q  <= i_frm_content_classifier_mirror;
			s_port_q  <= i_frm_port;
			s_dmac_q  <= i_frm_dmac;
			s_fwd_q   <= i_frm_fwd_mask;
			s_cpuq_q  <= i_frm_cpu_queue;
		end
	end

	// ==========================================================
	// redirect and mirror decision
	wire slow_hit = s_dmac_q == SLOW_PROTO_MAC && slow_q[s_port_q]; // [RULE_01]
	wire igmp_hit = s_igmp_q && v4_q[s_port_q]; // [RULE_13] [RULE_15]
	wire mld_hit  = s_mld_q && v6_q[s_port_q]; // [RULE_14] [RULE_15]
	wire redirect = slow_hit | igmp_hit | mld_hit;
	wire [PW-1:0] cpu_only = PW'(1) << CPU;
	wire [PW-1:0] fwd_eff  = redirect ? cpu_only : s_fwd_q;
	wire [Q_W-1:0] redir_q = igmp_hit ? q_igmp : mld_hit ? q_mld : q_slow;
	wire cpu_bound = fwd_eff[CPU];

	wire m_ing  = ing_q[s_port_q]; // [RULE_02] [RULE_11]
	wire m_egr  = |(fwd_eff[NUM_PORTS-1:0] & egr_q[NUM_PORTS-1:0]); // [RULE_03] [RULE_11]
	wire m_vlan = vlan_rd; // [RULE_04]
	wire m_cpu  = ctrl_q[CTL_MIR_CPU] && cpu_bound; // [RULE_05]
	wire m_lrn  = ctrl_q[CTL_LRN_MIR] && s_learn_q; // [RULE_08]
	wire m_content_classifier = s_content_classifier_q; // [RULE_09]
	// any number of causes collapse into one copy per destination port
	wire m_hit  = m_ing | m_egr | m_vlan | m_cpu | m_lrn | m_content_classifier; // [RULE_10] [RULE_18]

	logic [31:0] mir_cnt_q;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_dec_valid        <= 1'b0;
			o_fwd_mask         <= '0;
			o_cpu_queue        <= '0;
			o_mirror_mask      <= '0;
			o_mirror_cpu_queue <= '0;
			mir_cnt_q          <= RST_ZERO;
		end else begin
			o_dec_valid        <= s_valid_q;
			o_fwd_mask         <= s_valid_q ? fwd_eff : '0; // [RULE_18]
			o_cpu_queue        <= redirect ? redir_q : s_cpuq_q; // [RULE_15]
			o_mirror_mask      <= (s_valid_q && m_hit) ? dest_m : '0;
			o_mirror_cpu_queue <= q_mirror; // [RULE_07]
			if (s_valid_q && m_hit) mir_cnt_q <= mir_cnt_q + 32'h00000001;
		end
	end

	// ==========================================================
	// MAC table access
	fmcr_state_t        st_q;
	fmcr_cmd_t          cmd_q;
	logic               found_q;
	logic [31:0]        idx_q, lo_q, hi_q;
	logic [MAC_AW-1:0]  ptr_q;
	logic [MAC_ENTRY_W-1:0] mac_rd;

	wire       cmd_go   = w_cmd && st_q == ST_IDLE;
	wire [31:0] cmd_wv  = strb_merge(RST_ZERO, i_wdata, i_wstrb);
	wire [1:0] cmd_new  = cmd_wv[1:0];
	wire       mac_we   = cmd_go && cmd_new == CMD_WRITE; // [RULE_17]
	wire [MAC_AW-1:0] idx_a = idx_q[MAC_AW-1:0];
	wire       idx_last = idx_a == MAC_AW'(MAC_DEPTH - 1);
	wire       ptr_last = ptr_q == MAC_AW'(MAC_DEPTH - 1);
	wire       ent_vld  = mac_rd[MAC_ENTRY_W-1];
	wire       chk      = st_q == ST_CHECK;
	wire       take     = chk && (cmd_q == CMD_READ || ent_vld);
	wire [MAC_ENTRY_W-1:0] mac_wv = {hi_q[HI_VALID_BIT],
	                                 hi_q[HI_VID_LSB +: VID_W],
	                                 hi_q[15:0], lo_q};

	fmcr_ram #(
		.WIDTH (MAC_ENTRY_W),
		.DEPTH (MAC_DEPTH)
	) u_mac_table (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_we      (mac_we),
		.i_waddr   (idx_a),
		.i_wdata   (mac_wv),
		.i_raddr   (ptr_q),
		.o_rdata   (mac_rd)
	);

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q    <= ST_IDLE;
			cmd_q   <= CMD_IDLE;
			found_q <= 1'b0;
			ptr_q   <= '0;
		end else begin
			case (st_q)
			ST_IDLE: begin
				if (cmd_go) begin
					cmd_q <= fmcr_cmd_t'(cmd_new);
					found_q <= cmd_new == CMD_WRITE;
					if (cmd_new == CMD_READ) begin // [RULE_17]
						ptr_q <= idx_a;
						st_q  <= ST_FETCH;
					end else if (cmd_new == CMD_GETNEXT && !idx_last) begin // [RULE_16]
						ptr_q <= idx_a + MAC_AW'(1);
						st_q  <= ST_FETCH;
					end
				end
			end
			ST_FETCH: begin
				st_q <= ST_CHECK;
			end
			ST_CHECK: begin
				if (take || ptr_last) begin
					found_q <= take;
					st_q    <= ST_IDLE;
				end else begin
					ptr_q <= ptr_q + MAC_AW'(1);
					st_q  <= ST_FETCH;
				end
			end
			default: begin
				st_q <= ST_IDLE;
			end
			endcase
		end
	end

	// entry words: low = MAC[31:0]; high = valid, VID, MAC[47:32]
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idx_q <= RST_ZERO;
			lo_q  <= RST_ZERO;
			hi_q  <= RST_ZERO;
		end else if (take) begin // [RULE_16]
			idx_q <= 32'(ptr_q);
			lo_q  <= mac_rd[31:0];
			hi_q  <= {mac_rd[MAC_ENTRY_W-1], 3'h0,
			          mac_rd[MAC_ENTRY_W-2 -: VID_W], mac_rd[47:32]};
		end else begin
			if (w_idx) idx_q <= strb_merge(idx_q, i_wdata, i_wstrb);
			if (w_lo)  lo_q  <= strb_merge(lo_q, i_wdata, i_wstrb);
			if (w_hi)  hi_q  <= strb_merge(hi_q, i_wdata, i_wstrb);
		end
	end

	// ==========================================================
	// read data path
	wire busy = st_q != ST_IDLE;
	wire [31:0] cmd_rd = {busy, 28'h0000000, found_q, cmd_q};
	wire r_ok = ra <= OFF_MIR_CNT && ra[1:0] == 2'h0;
	wire [31:0] rd_mux =
		ra == OFF_CTRL     ? ctrl_q :
		ra == OFF_MIR_DEST ? dest_q :
		ra == OFF_EGR_MASK ? egr_q  :
		ra == OFF_ING_EN   ? ing_q  :
		ra == OFF_SLOW_EN  ? slow_q :
		ra == OFF_V4_EN    ? v4_q   :
		ra == OFF_V6_EN    ? v6_q   :
		ra == OFF_CPUQ     ? cpuq_q :
		ra == OFF_VLAN     ? vlan_q :
		ra == OFF_MAC_IDX  ? idx_q  :
		ra == OFF_MAC_LO   ? lo_q   :
		ra == OFF_MAC_HI   ? hi_q   :
		ra == OFF_MAC_CMD  ? cmd_rd :
		ra == OFF_MIR_CNT  ? mir_cnt_q : RST_ZERO;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= RST_ZERO;
			rresp_q  <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q  <= r_ok ? rd_mux : RST_ZERO;
			rresp_q  <= r_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (i_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign o_awready = aw_rdy_q;
	assign o_wready  = aw_rdy_q;
	assign o_bvalid  = bvalid_q;
	assign o_bresp   = bresp_q;
	assign o_arready = ar_rdy_q;
	assign o_rvalid  = rvalid_q;
	assign o_rdata   = rdata_q;
	assign o_rresp   = rresp_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	property p_slow;
		s_valid_q && s_dmac_q == SLOW_PROTO_MAC && slow_q[s_port_q] &&
		!(s_igmp_q && v4_q[s_port_q]) && !(s_mld_q && v6_q[s_port_q])
		|=> o_fwd_mask == cpu_only && o_cpu_queue == $past(q_slow);
	endproperty
	a_slow: assert property (p_slow) else $error("slow frame not redirected"); // [RULE_01]

	property p_ing;
		s_valid_q && ing_q[s_port_q] |=> o_mirror_mask == $past(dest_m);
	endproperty
	a_ing: assert property (p_ing) else $error("ingress copy missing"); // [RULE_02]

	property p_egr;
		s_valid_q && !redirect && |(s_fwd_q[NUM_PORTS-1:0] &
		egr_q[NUM_PORTS-1:0]) |=> o_mirror_mask == $past(dest_m);
	endproperty
	a_egr: assert property (p_egr) else $error("egress copy missing"); // [RULE_03]

	property p_vlan;
		s_valid_q && vlan_rd |=> o_mirror_mask == $past(dest_m);
	endproperty
	a_vlan: assert property (p_vlan) else $error("vlan copy missing"); // [RULE_04]

	property p_cpu;
		s_valid_q && ctrl_q[CTL_MIR_CPU] && (redirect || s_fwd_q[CPU])
		|=> o_mirror_mask == $past(dest_m) && o_fwd_mask[CPU];
	endproperty
	a_cpu: assert property (p_cpu) else $error("cpu copy missing"); // [RULE_05]

	property p_mq;
		o_dec_valid && o_mirror_mask[CPU] |-> o_mirror_cpu_queue ==
		$past(q_mirror);
	endproperty
	a_mq: assert property (p_mq) else $error("mirror cpu queue wrong"); // [RULE_07]

	property p_lrn;
		s_valid_q && s_learn_q && ctrl_q[CTL_LRN_MIR]
		|=> o_mirror_mask == $past(dest_m);
	endproperty
	a_lrn: assert property (p_lrn) else $error("learn copy missing"); // [RULE_08]

	property p_content_classifier;
		s_valid_q && s_content_classifier_q |=> o_mirror_mask == $past(dest_m);
	endproperty
	a_content_classifier: assert property (p_content_classifier) else $error("classifier copy missing"); // [RULE_09]

	property p_igmp;
		s_valid_q && s_igmp_q && v4_q[s_port_q]
		|=> o_fwd_mask == cpu_only && o_cpu_queue == $past(q_igmp);
	endproperty
	a_igmp: assert property (p_igmp) else $error("ipv4 report not redirected"); // [RULE_13]

	property p_mld;
		s_valid_q && s_mld_q && v6_q[s_port_q] && !(s_igmp_q && v4_q[s_port_q])
		|=> o_fwd_mask == cpu_only && o_cpu_queue == $past(q_mld);
	endproperty
	a_mld: assert property (p_mld) else $error("ipv6 listener not redirected"); // [RULE_14]

	property p_fwd;
		s_valid_q && !redirect |=> o_fwd_mask == $past(s_fwd_q);
	endproperty
	a_fwd: assert property (p_fwd) else $error("forwarding altered"); // [RULE_18]

	property p_rd;
		cmd_go && cmd_new == CMD_READ |=> busy ##2 !busy;
	endproperty
	a_rd: assert property (p_rd) else $error("direct read timing wrong"); // [RULE_17]

	property p_gn;
		chk && cmd_q == CMD_GETNEXT && ent_vld |=> !busy && found_q &&
		idx_q[MAC_AW-1:0] == $past(ptr_q);
	endproperty
	a_gn: assert property (p_gn) else $error("get-next result wrong"); // [RULE_16]

endmodule

// ==== test/fmcr_egress_sink.sv ====
/*
 * Egress side stand-in: takes every decision and counts mirror copies.
 * Assumes one decision per cycle at most and no backpressure.
 */
`timescale 1ns/10ps
module fmcr_egress_sink #(
	parameter int PW = 9
) (
	input  wire logic          i_ref_clk,
	input  wire logic          i_rst_n,
	input  wire logic          i_dec_valid,
	input  wire logic [PW-1:0] i_mirror_mask,
	output int                 o_copies
);
	// one copy per set destination bit
	// mirror port keeps the probe port's egress setup, copies match
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_copies <= 0;
		else if (i_dec_valid)
			o_copies <= o_copies + $countones(i_mirror_mask);
	end
endmodule

// ==== test/tb_top.sv ====
/*
 * Self-checking bench: AXI4-Lite register traffic, random frames against
 * a queue model, MAC table commands.
 * Assumes the design's default parameters (8 front ports, CPU bit 8).
 */
`timescale 1ns/10ps
module tb_top import fmcr_pkg::*;;
	logic        i_ref_clk = 1'h0, i_rst_n = 1'h0, i_awvalid = 1'h0;
	logic        i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0;
	logic        i_rready = 1'h0, i_frm_valid = 1'h0, i_frm_igmp = 1'h0;
	logic        i_frm_mld = 1'h0, i_frm_learn = 1'h0;
	logic        i_frm_content_classifier_mirror = 1'h0;
	logic [7:0]  i_awaddr = 8'h0, i_araddr = 8'h0;
	logic [31:0] i_wdata = 32'h0, rd_v, cfg [8];
	logic [3:0]  i_wstrb = 4'hF, i_frm_port = 4'h0, vf;
	logic [47:0] i_frm_dmac = 48'h0;
	logic [11:0] i_frm_vid = 12'h0;
	logic [8:0]  i_frm_fwd_mask = 9'h0, o_fwd_mask, o_mirror_mask;
	logic [2:0]  i_frm_cpu_queue = 3'h0, o_cpu_queue, o_mirror_cpu_queue;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic        o_dec_valid;
	logic [1:0]  o_bresp, o_rresp, rsp;
	logic [31:0] o_rdata;
	logic [23:0] exq [$];
	int          error_cnt = 0, n_tests = 0, seed = 14816;
	int          mcnt = 0, copies = 0, sink_copies;
	localparam logic [31:0] MSK [8] = '{32'h3, 32'h1FF, 32'hFF, 32'hFF,
		32'hFF, 32'hFF, 32'hFF, 32'h7777};

	always #2 i_ref_clk = ~i_ref_clk;

	fmcr_top dut (.i_ref_clk, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr,
		.i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready,
		.o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready,
		.o_rdata, .o_rresp, .i_frm_valid, .i_frm_port, .i_frm_dmac,
		.i_frm_igmp, .i_frm_mld, .i_frm_vid, .i_frm_fwd_mask,
		.i_frm_cpu_queue, .i_frm_learn, .i_frm_content_classifier_mirror, .o_dec_valid,
		.o_fwd_mask, .o_cpu_queue, .o_mirror_mask, .o_mirror_cpu_queue);
	fmcr_egress_sink sink (.i_ref_clk, .i_rst_n, .i_dec_valid(o_dec_valid),
		.i_mirror_mask(o_mirror_mask), .o_copies(sink_copies));

	// ==========================================================
	// helpers
	task automatic final_report();
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tick(inout int n);
		@(posedge i_ref_clk);
		n++;
		if (n > 300) begin
			error_cnt++;
			final_report();
		end
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		tick(n);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		i_bready <= 1'h1;
		do tick(n); while (!(o_awready === 1'h1 && o_wready === 1'h1));
		i_awvalid <= 1'h0;
		i_wvalid <= 1'h0;
		do tick(n); while (o_bvalid !== 1'h1);
		rsp = o_bresp;
		i_bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		tick(n);
		i_araddr <= a;
		i_arvalid <= 1'h1;
		i_rready <= 1'h1;
		do tick(n); while (o_arready !== 1'h1);
		i_arvalid <= 1'h0;
		do tick(n); while (o_rvalid !== 1'h1);
		rd_v = o_rdata;
		rsp = o_rresp;
		i_rready <= 1'h0;
	endtask

	task automatic poll();
		int n;
		n = 0;
		do begin
			rd(OFF_MAC_CMD);
			n++;
		end while (rd_v[31] !== 1'h0 && n < 50);
		chk(rd_v[31], 32'h0);
	endtask

	// random frame plus its expected decision
	task automatic frame();
		int         p, ig, ml, v, lr, vc, sl, q;
		logic [8:0] fw, fe;
		logic       rdf, h;
		@(posedge i_ref_clk);
		p = $random(seed) & 7;
		ig = $random(seed) & 1;
		ml = $random(seed) & 1;
		v = $random(seed) & 3;
		lr = $random(seed) & 1;
		vc = (($random(seed) & 7) == 0);
		sl = $random(seed) & 1;
		q = $random(seed) & 7;
		fw = 9'($random(seed));
		i_frm_valid <= 1'h1;
		i_frm_port <= p[3:0];
		i_frm_dmac <= sl ? SLOW_PROTO_MAC : SLOW_PROTO_MAC + 48'h1;
		i_frm_igmp <= ig[0];
		i_frm_mld <= ml[0];
		i_frm_vid <= v[11:0];
		i_frm_fwd_mask <= fw;
		i_frm_cpu_queue <= q[2:0];
		i_frm_learn <= lr[0];
		i_frm_content_classifier_mirror <= vc[0];
		rdf = (sl && cfg[4][p]) || (ig && cfg[5][p]) || (ml && cfg[6][p]);
		if (ig && cfg[5][p]) q = cfg[7][6:4];
		else if (ml && cfg[6][p]) q = cfg[7][10:8];
		else if (sl && cfg[4][p]) q = cfg[7][14:12];
		fe = rdf ? 9'h100 : fw;
		h = cfg[3][p] | (|(fe[7:0] & cfg[2][7:0])) | vf[v]
			| (cfg[0][0] & fe[8]) | (cfg[0][1] & lr[0]) | vc[0];
		exq.push_back({fe, q[2:0], h ? cfg[1][8:0] : 9'h0, cfg[7][2:0]});
		mcnt += h;
		copies += h ? $countones(cfg[1][8:0]) : 0;
	endtask

	always @(posedge i_ref_clk) begin
		if (o_dec_valid === 1'h1) begin
			if (exq.size() == 0)
				chk(32'h1, 32'h0); // decision without a frame
			else
				chk({o_fwd_mask, o_cpu_queue, o_mirror_mask, o_mirror_cpu_queue},
					exq.pop_front()); // decision
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (12) @(posedge i_ref_clk);
		i_rst_n <= 1'h1;
		for (int i = 0; i < 14; i++) begin
			rd(8'(4 * i));
			chk(rd_v, 32'h0);
		end
		rd(8'h38);
		chk(rsp, RESP_SLVERR);
		chk(rd_v, 32'h0);
		wr(8'h3C, 32'hFFFFFFFF);
		chk(rsp, RESP_SLVERR);
		wr(OFF_MIR_CNT, 32'h55);
		chk(rsp, RESP_OKAY);
		for (int ph = 0; ph < 6; ph++) begin
			for (int i = 0; i < 8; i++) begin
				cfg[i] = $random(seed) & $random(seed) & MSK[i];
				if (ph == 0) cfg[i] = 32'h0;
				wr(8'(4 * i), cfg[i]);
			end
			for (int i = 0; i < 4; i++) begin
				vf[i] = ($random(seed) % 2 != 0) && ph > 0;
				wr(OFF_VLAN, {15'h0, vf[i], 4'h0, 12'(i)});
			end
			repeat (60) frame();
			@(posedge i_ref_clk);
			i_frm_valid <= 1'h0;
			repeat (4) @(posedge i_ref_clk);
			chk(exq.size(), 32'h0); // every frame decided once
			rd(OFF_MIR_CNT);
			chk(rd_v, mcnt); // mirrored frames counted
			chk(sink_copies, copies); // copies per port
		end
		// entry 5 valid, entries 3 and 4 invalid
		wr(OFF_MAC_IDX, 32'h5);
		wr(OFF_MAC_LO, 32'hCAFE0123);
		wr(OFF_MAC_HI, 32'h81234567);
		wr(OFF_MAC_CMD, 32'h2);
		for (int i = 3; i < 5; i++) begin
			wr(OFF_MAC_IDX, i);
			wr(OFF_MAC_HI, 32'h0);
			wr(OFF_MAC_CMD, 32'h2);
		end
		wr(OFF_MAC_IDX, 32'h2);
		wr(OFF_MAC_LO, 32'h0);
		wr(OFF_MAC_CMD, 32'h3);
		poll();
		chk(rd_v[2:0], 32'h7); // next entry found
		rd(OFF_MAC_IDX);
		chk(rd_v, 32'h5); // index of next entry
		for (int k = 0; k < 2; k++) begin
			if (k == 1) wr(OFF_MAC_LO, 32'h0);
			if (k == 1) wr(OFF_MAC_HI, 32'h0);
			if (k == 1) wr(OFF_MAC_CMD, 32'h1);
			if (k == 1) poll();
			rd(OFF_MAC_LO);
			chk(rd_v, 32'hCAFE0123); // entry low word
			rd(OFF_MAC_HI);
			chk(rd_v, 32'h81234567); // entry high word
		end
		wr(OFF_MAC_IDX, 32'hFF);
		wr(OFF_MAC_CMD, 32'h3);
		poll();
		chk(rd_v[2:0], 32'h3); // nothing past the last index
		final_report();
	end
endmodule
